// ---- hw/sirc_defines.svh ----
// Command codes, checksum settings, range constants and serial weights for identity readout
`ifndef SIRC_DEFINES_SVH
`define SIRC_DEFINES_SVH

`define SIRC_CMD_READ_ID 16'hE102
`define SIRC_CRC_POLY 8'h31
`define SIRC_CRC_INIT 8'hFF
`define SIRC_CRC_XOROUT 8'h00
`define SIRC_CRC_TEST_WORD 16'hBEEF
`define SIRC_CRC_TEST_SUM 8'h92
`define SIRC_RESP_WORDS 3'h6
`define SIRC_CRC_POS 2'h2
`define SIRC_FILL_BYTE 8'hFF
`define SIRC_STATUS_PROTO 4'h8
`define SIRC_STATUS_FINAL 4'h1
`define SIRC_DEC_YEAR_W 64'h0000_0000_05F5_E100
`define SIRC_DEC_WEEK_W 64'h0000_0000_000F_4240
`define SIRC_SCALE_20 16'h09C4
`define SIRC_SCALE_50 16'h03E8
`define SIRC_SCALE_TEMP 16'h00C8
`define SIRC_OFFSET_FLOW 16'h9000
`define SIRC_OFFSET_TEMP 16'h0000

`endif

// ---- hw/sirc_pkg.sv ----
// Types shared by the identity readout block and its users
package sirc_pkg;

    typedef enum logic [1:0] {SIRC_IDLE, SIRC_CMD_WAIT, SIRC_CMD_LO, SIRC_ARMED} sirc_state_e;

    typedef enum logic [2:0] {
        SIRC_GAS_O2, SIRC_GAS_AIR, SIRC_GAS_N2O, SIRC_GAS_CO2,
        SIRC_MIX_AIR_O2, SIRC_MIX_N2O_O2, SIRC_MIX_CO2_O2, SIRC_SIG_TEMP
    } sirc_signal_e;

    // Byte path from the bus slave
    typedef struct packed {
        logic wr_start;
        logic wr_valid;
        logic [7:0] wr_data;
        logic rd_start;
        logic rd_req;
    } sirc_xfer_s;

    // Calibration fuses that make up the serial number
    typedef struct packed {
        logic [6:0] year;
        logic [5:0] week;
        logic [19:0] seq;
    } sirc_cal_s;

    typedef struct packed {
        logic [15:0] scale;
        logic [15:0] offset;
        logic valid;
    } sirc_conv_s;

    typedef struct packed {
        sirc_state_e state;
        logic [7:0] cmd_hi;
        logic [2:0] word_idx;
        logic [1:0] pos;
        logic [95:0] ident;
        logic [7:0] rd_data;
        logic rd_valid;
        logic cmd_accept;
        logic cmd_reject;
        logic resp_done;
        sirc_conv_s conv;
    } sirc_state_s;

endpackage

// ---- hw/sirc_top.sv ----
// Identity readout command, per-word checksum and conversion constant lookup
//
// Operation
// - Command 0xE102 after a write header arms the identity response for the next read.
// - Command accepted only while idle; refused while a measurement runs.
// - Response is 18 bytes, MSB first: product two words, serial four words, checksum each.
// - Lowest 4 bits of the product number hold the revision.
// - Serial number is a unique 64-bit unsigned integer across four words.
// - Serial in decimal reads year, week, then six-digit sequence number.
// - Hex digit above the last one: 8 prototype, 1 production part.
// - Each two-byte word is followed by a checksum over those two bytes only.
// - Checksum polynomial 0x31, init 0xFF, no reflection, final XOR 0x00.
// - 20 slm range: flow scale 2500, offset -28672; temperature 200, offset 0.
// - 50 slm range: scale 1000, offset -28672 for O2, air, air-O2 only.
`timescale 1ns/1ps
`default_nettype none
`include "sirc_defines.svh"

module sirc_top #(
    parameter logic [23:0] PRODUCT_VARIANT = 24'h00A5C3, // Arbitrary value
    parameter logic [3:0] REV_MINOR = 4'h0,
    parameter bit PROTOTYPE = 1'b0,
    parameter int RESP_WORDS = 6
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Command path
    input wire sirc_pkg::sirc_xfer_s xfer,
    input wire logic meas_active,
    input wire sirc_pkg::sirc_cal_s cal,
    // Read response
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic cmd_accept,
    output logic cmd_reject,
    output logic resp_done,
    // Conversion lookup
    input wire sirc_pkg::sirc_signal_e conv_sel,
    input wire logic range_50,
    output sirc_pkg::sirc_conv_s conv
);

    if (RESP_WORDS != 6)
    begin : g_check
        $error("Identity response layout is fixed at six words");
    end

    sirc_pkg::sirc_state_s q;
    sirc_pkg::sirc_state_s d;

    function automatic logic [7:0] crc8(input logic [15:0] word);
        logic [7:0] c;
        logic fb;
        c = `SIRC_CRC_INIT;
        for (int i = 15; i >= 0; i--)
        begin
            fb = c[7] ^ word[i];
            c = {c[6:0], 1'b0} ^ (fb ? `SIRC_CRC_POLY : 8'h00);
        end
        return c ^ `SIRC_CRC_XOROUT;
    endfunction

    function automatic logic [15:0] word_sel(input logic [95:0] id, input logic [2:0] idx);
        return id[8'(95 - 16 * idx) -: 16];
    endfunction

    function automatic logic [63:0] serial_of(input sirc_pkg::sirc_cal_s c);
        return {57'h0, c.year} * `SIRC_DEC_YEAR_W + {58'h0, c.week} * `SIRC_DEC_WEEK_W + {44'h0, c.seq};
    endfunction

    function automatic sirc_pkg::sirc_conv_s lookup(input sirc_pkg::sirc_signal_e s, input logic r50);
        sirc_pkg::sirc_conv_s v;
        v = '{scale: `SIRC_SCALE_20, offset: `SIRC_OFFSET_FLOW, valid: 1'b1};
        if (s == sirc_pkg::SIRC_SIG_TEMP)
        begin
            v = '{scale: `SIRC_SCALE_TEMP, offset: `SIRC_OFFSET_TEMP, valid: 1'b1};
        end
        else if (r50)
        begin
            v.scale = `SIRC_SCALE_50;
            // Wide range has no tables for the nitrous-oxide and CO2 signals
            if (s == sirc_pkg::SIRC_GAS_N2O || s == sirc_pkg::SIRC_GAS_CO2 ||
                s == sirc_pkg::SIRC_MIX_N2O_O2 || s == sirc_pkg::SIRC_MIX_CO2_O2)
            begin
                v = '{scale: 16'h0000, offset: 16'h0000, valid: 1'b0};
            end
        end
        return v;
    endfunction

    logic [31:0] product;
    assign product = {PRODUCT_VARIANT, PROTOTYPE ? `SIRC_STATUS_PROTO : `SIRC_STATUS_FINAL, REV_MINOR};

    // Word under the read pointer; past the last word it is never used
    logic [15:0] cur_word;
    assign cur_word = word_sel(q.ident, q.word_idx);

    always_comb
    begin
        d = q;
        d.rd_valid = 1'b0;
        d.cmd_accept = 1'b0;
        d.cmd_reject = 1'b0;
        d.resp_done = 1'b0;
        d.conv = lookup(conv_sel, range_50);
        case (q.state)
            sirc_pkg::SIRC_IDLE:
            begin
                d.state = sirc_pkg::SIRC_IDLE;
            end
            sirc_pkg::SIRC_CMD_WAIT:
            begin
                // A byte beside a fresh write header is dropped
                if (xfer.wr_valid && !xfer.wr_start)
                begin
                    d.cmd_hi = xfer.wr_data;
                    d.state = sirc_pkg::SIRC_CMD_LO;
                end
            end
            sirc_pkg::SIRC_CMD_LO:
            begin
                if (xfer.wr_valid && !xfer.wr_start)
                begin
                    d.state = sirc_pkg::SIRC_IDLE;
                    if ({q.cmd_hi, xfer.wr_data} == `SIRC_CMD_READ_ID)
                    begin
                        if (meas_active)
                        begin
                            d.cmd_reject = 1'b1;
                        end
                        else
                        begin
                            d.cmd_accept = 1'b1;
                            d.state = sirc_pkg::SIRC_ARMED;
                            d.ident = {product, serial_of(cal)};
                            d.word_idx = 3'h0;
                            d.pos = 2'h0;
                        end
                    end
                end
            end
            sirc_pkg::SIRC_ARMED:
            begin
                // A repeated read header restarts the response from byte one
                if (xfer.rd_start)
                begin
                    d.word_idx = 3'h0;
                    d.pos = 2'h0;
                end
            end
            default:
            begin
                d.state = sirc_pkg::SIRC_IDLE;
            end
        endcase
        if (xfer.rd_req && !xfer.rd_start)
        begin
            d.rd_valid = 1'b1;
            d.rd_data = `SIRC_FILL_BYTE;
            if (q.state == sirc_pkg::SIRC_ARMED && q.word_idx < `SIRC_RESP_WORDS)
            begin
                case (q.pos)
                    2'h0: d.rd_data = cur_word[15:8];
                    2'h1: d.rd_data = cur_word[7:0];
                    default: d.rd_data = crc8(cur_word);
                endcase
                if (q.pos == `SIRC_CRC_POS)
                begin
                    d.pos = 2'h0;
                    d.word_idx = q.word_idx + 3'h1;
                    d.resp_done = (q.word_idx == `SIRC_RESP_WORDS - 3'h1);
                end
                else
                begin
                    d.pos = q.pos + 2'h1;
                end
            end
        end
        // A new write header abandons any pending response
        if (xfer.wr_start)
        begin
            d.state = sirc_pkg::SIRC_CMD_WAIT;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            q <= '0;
            q.state <= sirc_pkg::SIRC_IDLE;
        end
        else
        begin
            q <= d;
        end
    end

    assign rd_data = q.rd_data;
    assign rd_valid = q.rd_valid;
    assign cmd_accept = q.cmd_accept;
    assign cmd_reject = q.cmd_reject;
    assign resp_done = q.resp_done;
    assign conv = q.conv;

    // Checker-only history of emitted bytes
    logic [15:0] hist_q;
    logic crc_slot_q;
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            hist_q <= 16'h0000;
            crc_slot_q <= 1'b0;
        end
        else
        begin
            if (q.rd_valid)
            begin
                hist_q <= {hist_q[7:0], q.rd_data};
            end
            crc_slot_q <= xfer.rd_req && !xfer.rd_start && q.state == sirc_pkg::SIRC_ARMED &&
                q.word_idx < `SIRC_RESP_WORDS && q.pos == `SIRC_CRC_POS;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    cmd_arm_a: assert property (q.state == sirc_pkg::SIRC_CMD_LO && xfer.wr_valid && !xfer.wr_start && !meas_active
        && {q.cmd_hi, xfer.wr_data} == `SIRC_CMD_READ_ID |=> cmd_accept && q.state == sirc_pkg::SIRC_ARMED)
        else $error("Identity command not armed");
    busy_refuse_a: assert property (q.state == sirc_pkg::SIRC_CMD_LO && xfer.wr_valid && !xfer.wr_start && meas_active
        && {q.cmd_hi, xfer.wr_data} == `SIRC_CMD_READ_ID |=> cmd_reject && !cmd_accept)
        else $error("Identity command taken while measuring");
    resp_length_a: assert property (resp_done |-> q.word_idx == `SIRC_RESP_WORDS && q.pos == 2'h0 && rd_valid)
        else $error("Response did not end after eighteen bytes");
    revision_field_a: assert property (cmd_accept |-> q.ident[67:64] == REV_MINOR)
        else $error("Revision not in low product bits");
    serial_value_a: assert property (cmd_accept |-> q.ident[63:0] == 64'd100000000 * $past(cal.year)
        + 64'd1000000 * $past(cal.week) + 64'($past(cal.seq)))
        else $error("Serial number mismatch");
    build_status_a: assert property (cmd_accept |-> q.ident[71:68] == (PROTOTYPE ? 4'h8 : 4'h1))
        else $error("Build status digit wrong");
    word_crc_a: assert property (crc_slot_q |-> rd_valid && rd_data == crc8(hist_q))
        else $error("Checksum byte does not cover preceding word");
    crc_check_a: assert property (crc8(`SIRC_CRC_TEST_WORD) == `SIRC_CRC_TEST_SUM)
        else $error("Checksum generator wrong");
    range20_a: assert property (!$past(srst) && !$past(range_50) && $past(conv_sel) != sirc_pkg::SIRC_SIG_TEMP
        |-> conv.valid && conv.scale == 16'h09C4 && conv.offset == 16'h9000)
        else $error("Narrow range constants wrong");
    range50_a: assert property ($past(range_50) && ($past(conv_sel) == sirc_pkg::SIRC_GAS_N2O
        || $past(conv_sel) == sirc_pkg::SIRC_GAS_CO2) |-> !conv.valid)
        else $error("Unavailable wide range entry reported valid");

endmodule // sirc_top
`default_nettype wire

// ---- test/sirc_host_model.sv ----
// Bus host model that sends commands and reads checked response words
`timescale 1ns/1ps
`default_nettype none

module sirc_host_model (
    // Clock
    input wire logic clk_sys,
    // Device side
    output sirc_pkg::sirc_xfer_s xfer,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic resp_done
);
    initial xfer = '0;

    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 15; i >= 0; i--)
        begin
            c = (c[7] ^ w[i]) ? ((c << 1) ^ 8'h31) : (c << 1);
        end
        return c;
    endfunction

    // Physical reading in whole units from a raw signed sample
    function automatic logic signed [31:0] to_phys(input logic [15:0] raw, input logic [15:0] off,
        input logic [15:0] scale);
        return (32'($signed(raw)) - 32'($signed(off))) / 32'($signed(scale));
    endfunction

    task automatic send_cmd(input logic [15:0] code);
        @(negedge clk_sys);
        xfer.wr_start = 1'b1;
        @(negedge clk_sys);
        xfer.wr_start = 1'b0;
        xfer.wr_valid = 1'b1;
        xfer.wr_data = code[15:8];
        @(negedge clk_sys);
        xfer.wr_data = code[7:0];
        @(negedge clk_sys);
        xfer.wr_valid = 1'b0;
        // Released data flips so stale bytes cannot look valid
        xfer.wr_data = ~code[7:0];
    endtask

    task automatic restart();
        @(negedge clk_sys);
        xfer.rd_start = 1'b1;
        @(negedge clk_sys);
        xfer.rd_start = 1'b0;
    endtask

    task automatic rd_byte(output logic [7:0] b, output logic last);
        logic got;
        got = 1'b0;
        b = 8'hXX;
        last = 1'bX;
        @(negedge clk_sys);
        xfer.rd_req = 1'b1;
        @(negedge clk_sys);
        xfer.rd_req = 1'b0;
        for (int i = 0; i < 3 && !got; i++)
        begin
            if (rd_valid === 1'b1)
            begin
                got = 1'b1;
                b = rd_data;
                last = resp_done;
            end
            else
                @(negedge clk_sys);
        end
    endtask

    task automatic read_word(output logic [15:0] w, output logic ok, output logic last);
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] c;
        logic l0;
        logic l1;
        rd_byte(b0, l0);
        rd_byte(b1, l1);
        rd_byte(c, last);
        w = {b0, b1};
        ok = (c === crc8(w)) && (l0 === 1'b0) && (l1 === 1'b0);
    endtask
endmodule // sirc_host_model
`default_nettype wire

// ---- test/sirc_top_tb.sv ----
// Testbench for the identity readout block
`timescale 1ns/1ps
`default_nettype none

module sirc_top_tb;
    localparam logic [23:0] VARIANT = 24'h5A3C96; // Arbitrary value
    localparam logic [3:0] REV = 4'h7;
    logic clk_sys;
    logic srst;
    sirc_pkg::sirc_xfer_s xfer;
    logic meas_active;
    sirc_pkg::sirc_cal_s cal;
    logic [7:0] rd_data;
    logic rd_valid;
    logic cmd_accept;
    logic cmd_reject;
    logic resp_done;
    sirc_pkg::sirc_signal_e conv_sel;
    logic range_50;
    sirc_pkg::sirc_conv_s conv;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;

    sirc_top #(.PRODUCT_VARIANT(VARIANT), .REV_MINOR(REV), .PROTOTYPE(1'b0), .RESP_WORDS(6)) sirc_top_i (
        .clk_sys(clk_sys), .srst(srst), .xfer(xfer), .meas_active(meas_active), .cal(cal),
        .rd_data(rd_data), .rd_valid(rd_valid), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
        .resp_done(resp_done), .conv_sel(conv_sel), .range_50(range_50), .conv(conv)
    );

    sirc_host_model sirc_host_model_i (
        .clk_sys(clk_sys), .xfer(xfer), .rd_data(rd_data), .rd_valid(rd_valid), .resp_done(resp_done)
    );

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic do_cmd(input logic [15:0] code, input logic exp_acc, input logic exp_rej);
        logic acc;
        logic rej;
        acc = 1'b0;
        rej = 1'b0;
        sirc_host_model_i.send_cmd(code);
        repeat (3)
        begin
            acc |= (cmd_accept === 1'b1);
            rej |= (cmd_reject === 1'b1);
            @(negedge clk_sys);
        end
        check(acc === exp_acc && rej === exp_rej, "command answer");
    endtask

    task automatic test_ident();
        logic [95:0] all;
        logic [15:0] w;
        logic ok;
        logic last;
        // Production part: status nibble 1 above the revision
        all = {VARIANT, 4'h1, REV, 64'd23 * 64'd100000000 + 64'd14 * 64'd1000000 + 64'd123456};
        do_cmd(16'hE102, 1'b1, 1'b0);
        for (int k = 0; k < 6; k++)
        begin
            sirc_host_model_i.read_word(w, ok, last);
            check(w === all[95 - 16 * k -: 16], "identity word");
            check(ok === 1'b1, "word checksum");
            check(last === (k == 5), "response end");
        end
        sirc_host_model_i.read_word(w, ok, last);
        check(w === 16'hFFFF, "fill after last byte");
    endtask

    task automatic test_refuse_restart();
        logic [15:0] w;
        logic ok;
        logic last;
        meas_active = 1'b1;
        do_cmd(16'hE102, 1'b0, 1'b1);
        meas_active = 1'b0;
        sirc_host_model_i.read_word(w, ok, last);
        check(w === 16'hFFFF, "no response after refusal");
        do_cmd(16'hE102, 1'b1, 1'b0);
        sirc_host_model_i.read_word(w, ok, last);
        sirc_host_model_i.restart();
        sirc_host_model_i.read_word(w, ok, last);
        check(w === VARIANT[23:8] && ok === 1'b1, "restart at first byte");
        // Another command drops the armed response
        do_cmd(16'h3661, 1'b0, 1'b0);
        sirc_host_model_i.read_word(w, ok, last);
        check(w === 16'hFFFF, "disarmed by new command");
    endtask

    task automatic test_conv();
        logic [15:0] scale;
        logic [15:0] off;
        logic [15:0] raw;
        logic v;
        for (int r = 0; r < 2; r++)
            for (int s = 0; s < 8; s++)
            begin
                range_50 = r[0];
                conv_sel = sirc_pkg::sirc_signal_e'(s[2:0]);
                @(negedge clk_sys);
                v = 1'b1;
                scale = r[0] ? 16'h03E8 : 16'h09C4;
                off = 16'h9000;
                if (s == 7)
                begin
                    scale = 16'h00C8;
                    off = 16'h0000;
                end
                else if (r == 1 && (s == 2 || s == 3 || s == 5 || s == 6))
                begin
                    v = 1'b0;
                    scale = 16'h0000;
                    off = 16'h0000;
                end
                check(conv === {scale, off, v}, "conversion constants");
                if (v)
                begin
                    raw = off + 16'h0003 * scale;
                    check(sirc_host_model_i.to_phys(raw, conv.offset, conv.scale) === 32'sd3, "physical value");
                end
            end
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: run took too long", $time);
            give_verdict();
        end
    end

    initial
    begin
        srst = 1'b1;
        meas_active = 1'b0;
        cal = {7'd23, 6'd14, 20'd123456};
        conv_sel = sirc_pkg::SIRC_GAS_O2;
        range_50 = 1'b0;
        repeat (6) @(negedge clk_sys);
        check(rd_valid === 1'b0 && conv === '0, "outputs held in reset");
        srst = 1'b0;
        test_ident();
        test_refuse_restart();
        test_conv();
        give_verdict();
    end
endmodule // sirc_top_tb
`default_nettype wire
